// file: lpf_top.sv
// LVDS pixel format control: register file, link sampling, lane output.
// Assumes the pixel clock and pixel bus come from another clock domain
// and are sampled here by aclk, which runs several times faster.
//
// Summary of operation
// - Vertical sync leaves high if its invert bit is 0, else low; reset 1.
// - Wide enable 0 gives 18-bit output, fourth lane off; 1 gives 24-bit.
// - 24-bit output puts colour MSBs on the fourth lane, LSBs if select 1.
// - Select 1 with wide off drops two colour LSBs, fourth lane stays off.
// - Data enable leaves high when its invert bit is 0, low when 1; reset 0.
// - Horizontal sync leaves high if its invert bit is 0, else low; reset 1.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
module lpf_top
  import lpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic pix_clk,
  input wire lpf_pixel_s pix_in,
  output lpf_lanes_s lane_words,
  output logic lane_strobe,
  output logic fourth_lane_enable,
  output logic link_active
);

  // ==========================================================
  // Bus engine
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  lpf_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axil_awaddr),
    .awvalid(s_axil_awvalid),
    .awready(s_axil_awready),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .wvalid(s_axil_wvalid),
    .wready(s_axil_wready),
    .bresp(s_axil_bresp),
    .bvalid(s_axil_bvalid),
    .bready(s_axil_bready),
    .araddr(s_axil_araddr),
    .arvalid(s_axil_arvalid),
    .arready(s_axil_arready),
    .rdata(s_axil_rdata),
    .rresp(s_axil_rresp),
    .rvalid(s_axil_rvalid),
    .rready(s_axil_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ==========================================================
  // Format register
  logic [7:0] fmt_q;
  lpf_reg_e wr_sel;
  lpf_reg_e rd_sel;
  lpf_fmt_s fmt;
  logic fmt_wr;

  assign wr_sel = lpf_decode(wr_addr);
  assign rd_sel = lpf_decode(rd_addr);
  assign wr_ok = (wr_sel != LPF_REG_NONE);
  assign rd_ok = (rd_sel != LPF_REG_NONE);
  assign fmt_wr = wr_en && (wr_sel == LPF_REG_FMT) && wr_strb[0];

  // Undefined bits 2 and 0 are not stored and read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_q <= FMT_RESET;
    end else if (fmt_wr) begin
      fmt_q <= (wr_data[7:0] & FMT_WMASK) | (fmt_q & ~FMT_WMASK);
    end
  end

  assign fmt.de_inv = fmt_q[FMT_DE_INV_BIT];
  assign fmt.hs_inv = fmt_q[FMT_HS_INV_BIT];
  assign fmt.vs_inv = fmt_q[FMT_VS_INV_BIT];
  assign fmt.wide = fmt_q[FMT_WIDE_BIT];
  assign fmt.low_sel = fmt_q[FMT_LOWSEL_BIT];

  // ==========================================================
  // Input synchronisers
  localparam int unsigned PIX_W = $bits(lpf_pixel_s);
  logic [PIX_W-1:0] pix_meta_q;
  logic [PIX_W-1:0] pix_sync_q;
  logic clk_meta_q;
  logic clk_sync_q;
  logic clk_prev_q;
  logic clk_rise;
  lpf_pixel_s pix_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_meta_q <= 1'b0;
      clk_sync_q <= 1'b0;
    end else begin
      clk_meta_q <= pix_clk;
      clk_sync_q <= clk_meta_q;
    end
  end

  // Delayed copy of the synced clock for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_sync_q;
    end
  end

  // Pixel bus is stable across a link period, so per-bit sync is safe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_meta_q <= '0;
      pix_sync_q <= '0;
    end else begin
      pix_meta_q <= pix_in;
      pix_sync_q <= pix_meta_q;
    end
  end

  assign clk_rise = clk_sync_q && !clk_prev_q;
  assign pix_s = lpf_pixel_s'(pix_sync_q);

  // ==========================================================
  // Link activity watch
  typedef enum logic {LINK_IDLE, LINK_RUN} lpf_link_e;
  lpf_link_e link_q;
  logic [IDLE_CNT_W-1:0] idle_cnt_q;
  localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = IDLE_CNT_W'(LINK_IDLE_CYC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt_q <= '0;
    end else if (clk_rise) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != IDLE_LIMIT) begin
      idle_cnt_q <= idle_cnt_q + IDLE_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_q <= LINK_IDLE;
    end else begin
      unique case (link_q)
        LINK_IDLE: if (clk_rise) link_q <= LINK_RUN;
        LINK_RUN: if (idle_cnt_q == IDLE_LIMIT) link_q <= LINK_IDLE;
      endcase
    end
  end

  assign link_active = (link_q == LINK_RUN);

  // ==========================================================
  // Lane formatting on each link clock edge
  lpf_lanes_s lanes_d;

  lpf_lane_map u_map (
    .pixel(pix_s),
    .fmt(fmt),
    .lanes(lanes_d)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_strobe <= 1'b0;
    end else begin
      lane_strobe <= clk_rise;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_words <= '0;
    end else if (clk_rise) begin
      lane_words <= lanes_d;
    end
  end

  // Lane enable follows the mode at the next link edge, with the data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fourth_lane_enable <= 1'b0;
    end else if (clk_rise) begin
      fourth_lane_enable <= fmt.wide;
    end
  end

  // ==========================================================
  // Frame and line counters
  logic vs_prev_q;
  logic hs_prev_q;
  logic in_frame_q;
  logic [15:0] frames_q;
  logic [15:0] line_cnt_q;
  logic [15:0] lines_q;
  logic vs_start;
  logic hs_start;

  assign vs_start = clk_rise && pix_s.vs && !vs_prev_q;
  assign hs_start = clk_rise && pix_s.hs && !hs_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vs_prev_q <= 1'b0;
    end else if (clk_rise) begin
      vs_prev_q <= pix_s.vs;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_prev_q <= 1'b0;
    end else if (clk_rise) begin
      hs_prev_q <= pix_s.hs;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames_q <= 16'h0000;
    end else if (vs_start) begin
      frames_q <= frames_q + 16'h0001;
    end
  end

  // Cleared once the link goes quiet; a frame start wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame_q <= 1'b0;
    end else if (vs_start) begin
      in_frame_q <= 1'b1;
    end else if (!link_active) begin
      in_frame_q <= 1'b0;
    end
  end

  // Lines of the previous frame are latched at each frame start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_cnt_q <= 16'h0000;
    end else if (vs_start) begin
      line_cnt_q <= 16'h0000;
    end else if (hs_start) begin
      line_cnt_q <= line_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lines_q <= 16'h0000;
    end else if (vs_start) begin
      lines_q <= line_cnt_q;
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_sel)
      LPF_REG_FMT: rd_data[7:0] = fmt_q;
      LPF_REG_STATUS: begin
        rd_data[STAT_LINK_BIT] = link_active;
        rd_data[STAT_LANE3_BIT] = fourth_lane_enable;
        rd_data[STAT_INFRAME_BIT] = in_frame_q;
      end
      LPF_REG_FRAMES: rd_data[15:0] = frames_q;
      LPF_REG_LINES: rd_data[15:0] = lines_q;
      LPF_REG_NONE: rd_data = 32'h0000_0000;
    endcase
  end

endmodule

// file: lpf_pkg.sv
// Shared constants, types and decode helpers for the LVDS pixel format block.
// Assumes a 25 MHz register clock and an AXI4-Lite register port.
package lpf_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned LINK_IDLE_NS = 2000;
  localparam int unsigned LINK_IDLE_CYC = LINK_IDLE_NS / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CNT_W = 8;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] FMT_OFFSET = 8'h18;
  localparam logic [7:0] STATUS_OFFSET = 8'h1c;
  localparam logic [7:0] FRAMES_OFFSET = 8'h20;
  localparam logic [7:0] LINES_OFFSET = 8'h24;

  // Format register fields
  localparam int unsigned FMT_DE_INV_BIT = 7;
  localparam int unsigned FMT_HS_INV_BIT = 6;
  localparam int unsigned FMT_VS_INV_BIT = 5;
  localparam int unsigned FMT_RSVD_BIT = 4;
  localparam int unsigned FMT_WIDE_BIT = 3;
  localparam int unsigned FMT_LOWSEL_BIT = 1;
  localparam logic [7:0] FMT_RESET = 8'h70;
  localparam logic [7:0] FMT_WMASK = 8'hfa;

  // Status register fields
  localparam int unsigned STAT_LINK_BIT = 0;
  localparam int unsigned STAT_LANE3_BIT = 1;
  localparam int unsigned STAT_INFRAME_BIT = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    LPF_REG_FMT,
    LPF_REG_STATUS,
    LPF_REG_FRAMES,
    LPF_REG_LINES,
    LPF_REG_NONE
  } lpf_reg_e;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic de;
    logic hs;
    logic vs;
  } lpf_pixel_s;

  typedef struct packed {
    logic [6:0] lane3;
    logic [6:0] lane2;
    logic [6:0] lane1;
    logic [6:0] lane0;
  } lpf_lanes_s;

  typedef struct packed {
    logic de_inv;
    logic hs_inv;
    logic vs_inv;
    logic wide;
    logic low_sel;
  } lpf_fmt_s;

  // Address decode shared by read and write paths
  function automatic lpf_reg_e lpf_decode(input logic [7:0] addr);
    unique case (addr)
      FMT_OFFSET: lpf_decode = LPF_REG_FMT;
      STATUS_OFFSET: lpf_decode = LPF_REG_STATUS;
      FRAMES_OFFSET: lpf_decode = LPF_REG_FRAMES;
      LINES_OFFSET: lpf_decode = LPF_REG_LINES;
      default: lpf_decode = LPF_REG_NONE;
    endcase
  endfunction

endpackage

// file: lpf_axil_slave.sv
// AXI4-Lite slave protocol engine: one write and one read in flight.
// Assumes the parent decodes addresses and supplies read data at once.
module lpf_axil_slave
  import lpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign awready = !aw_held_q && !bvalid;
  assign wready = !w_held_q && !bvalid;
  assign arready = !rvalid;
  assign wr_en = aw_held_q && w_held_q && !bvalid;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_addr = araddr;

  // ==========================================================
  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_en) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_en) begin
      w_held_q <= 1'b0;
    end
  end

  // ==========================================================
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_data : 32'h0000_0000;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// file: lpf_lane_map.sv
// Pixel to LVDS lane word mapping, purely combinational.
// Assumes colour fields are 8 bits; 18-bit input sits in bits 7:2.
module lpf_lane_map
  import lpf_pkg::*;
(
  input wire lpf_pixel_s pixel,
  input wire lpf_fmt_s fmt,
  output lpf_lanes_s lanes
);

  logic [5:0] r6;
  logic [5:0] g6;
  logic [5:0] b6;
  logic hs_out;
  logic vs_out;
  logic de_out;
  logic msb_mode;

  // Fourth lane carries colour MSBs only for wide output with select 0
  assign msb_mode = fmt.wide && !fmt.low_sel;

  always_comb begin
    if (msb_mode) begin
      r6 = pixel.red[5:0];
      g6 = pixel.green[5:0];
      b6 = pixel.blue[5:0];
    end else begin
      r6 = pixel.red[7:2];
      g6 = pixel.green[7:2];
      b6 = pixel.blue[7:2];
    end
  end

  assign de_out = fmt.de_inv ? !pixel.de : pixel.de;
  assign hs_out = fmt.hs_inv ? !pixel.hs : pixel.hs;
  assign vs_out = fmt.vs_inv ? !pixel.vs : pixel.vs;

  assign lanes.lane0 = {g6[0], r6};
  assign lanes.lane1 = {b6[1:0], g6[5:1]};
  assign lanes.lane2 = {de_out, vs_out, hs_out, b6[5:2]};

  always_comb begin
    if (!fmt.wide) begin
      lanes.lane3 = 7'h00;
    end else if (fmt.low_sel) begin
      lanes.lane3 = {1'b0, pixel.blue[1:0], pixel.green[1:0],
                     pixel.red[1:0]};
    end else begin
      lanes.lane3 = {1'b0, pixel.blue[7:6], pixel.green[7:6],
                     pixel.red[7:6]};
    end
  end

endmodule

// file: lpf_chk.sv
// Port checks for the LVDS pixel format block.
// Assumes one aclk domain with synchronous active-low reset.
module lpf_chk
  import lpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_awready,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire lpf_lanes_s lane_words,
  input wire logic lane_strobe,
  input wire logic fourth_lane_enable,
  input wire logic link_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Cycles since last lane update
  logic [7:0] idle_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || lane_strobe) begin
      idle_q <= 8'h00;
    end else if (idle_q != 8'h3c) begin
      idle_q <= idle_q + 8'h01;
    end
  end
  // ==========================================================
  // Assertions
  property p_strobe_pulse;
    lane_strobe |=> !lane_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("lane strobe longer than one cycle");
  property p_words_change;
    $changed(lane_words) |-> lane_strobe;
  endproperty
  a_words_change: assert property (p_words_change)
    else $error("lane words changed without strobe");
  property p_lane3_off;
    lane_strobe && !fourth_lane_enable |-> lane_words.lane3 == 7'h00;
  endproperty
  a_lane3_off: assert property (p_lane3_off)
    else $error("fourth lane carries data while off");
  property p_lane3_top;
    lane_strobe |-> !lane_words.lane3[6];
  endproperty
  a_lane3_top: assert property (p_lane3_top)
    else $error("fourth lane top bit set");
  property p_lane_en_step;
    $changed(fourth_lane_enable) |-> lane_strobe;
  endproperty
  a_lane_en_step: assert property (p_lane_en_step)
    else $error("fourth lane enable moved without strobe");
  property p_link_on;
    lane_strobe |=> link_active [*8];
  endproperty
  a_link_on: assert property (p_link_on)
    else $error("link not active after pixel");
  property p_link_off;
    idle_q == 8'h3c |-> !link_active;
  endproperty
  a_link_off: assert property (p_link_off)
    else $error("link still active when idle");
  property p_b_done;
    s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response not released");
  property p_w_lock;
    s_axil_bvalid |-> !s_axil_awready && !s_axil_wready;
  endproperty
  a_w_lock: assert property (p_w_lock)
    else $error("write accepted during response");
  property p_ar_lock;
    s_axil_rvalid |-> !s_axil_arready;
  endproperty
  a_ar_lock: assert property (p_ar_lock)
    else $error("read accepted during response");
  c_wide: cover property (lane_strobe && fourth_lane_enable);
  c_slverr: cover property (s_axil_bvalid && s_axil_bresp == RESP_SLVERR);
  c_idle: cover property (idle_q == 8'h3c);
endmodule
bind lpf_top lpf_chk i_chk (.aclk, .aresetn, .s_axil_awready,
  .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
  .s_axil_arready, .s_axil_rvalid, .lane_words, .lane_strobe,
  .fourth_lane_enable, .link_active);

// file: lpf_panel_model.sv
// Panel-side model: takes one lane word set per strobe.
// Assumes lane_strobe marks a new pixel in the aclk domain.
module lpf_panel_model
  import lpf_pkg::*;
(
  input wire logic aclk,
  input wire lpf_lanes_s lane_words,
  input wire logic lane_strobe,
  output lpf_lanes_s seen,
  output logic [15:0] pixels
);
  initial begin
    seen = '0;
    pixels = 16'h0000;
  end
  always @(posedge aclk) begin
    if (lane_strobe) begin
      seen <= lane_words;
      pixels <= pixels + 16'h0001;
    end
  end
endmodule

// file: lpf_top_tb.sv
// Testbench for the LVDS pixel format block with a panel model.
// Assumes package, design, checker and panel model compile first.
module lpf_top_tb
  import lpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pix_clk;
  logic lane_strobe, fle, link_active;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] pixels;
  lpf_pixel_s pix_in;
  lpf_lanes_s lane_words, seen;
  int fail_count = 0;
  int comparisons = 0;
  logic [3:0] wstrb_use = 4'hf;
  lpf_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .pix_clk(pix_clk), .pix_in(pix_in),
    .lane_words(lane_words), .lane_strobe(lane_strobe),
    .fourth_lane_enable(fle), .link_active(link_active));
  lpf_panel_model i_panel (.aclk(aclk), .lane_words(lane_words),
    .lane_strobe(lane_strobe), .seen(seen), .pixels(pixels));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ==========================================================
  // Common tasks
  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic tmo();
    fail_count++;
    $display("wrong value at %0t: no bus answer", $time);
    stop_test();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= wstrb_use;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 20) tmo();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 20) tmo();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic send_px(input logic [23:0] c, input logic [2:0] s);
    int i;
    logic [15:0] n;
    n = pixels;
    @(posedge aclk);
    pix_in <= {c, s};
    @(posedge aclk);
    pix_clk <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge aclk);
      if (i == 3) pix_clk <= 1'b0;
    end
    chk(32'(pixels), 32'(n + 16'h0001), "pixel count");
  endtask
  function automatic lpf_lanes_s exp_lanes(input logic [7:0] f,
      input logic [23:0] c, input logic [2:0] s);
    logic [7:0] r, g, b;
    logic [5:0] r6, g6, b6;
    logic [6:0] l3;
    {r, g, b} = c;
    r6 = (f[3] && !f[1]) ? r[5:0] : r[7:2];
    g6 = (f[3] && !f[1]) ? g[5:0] : g[7:2];
    b6 = (f[3] && !f[1]) ? b[5:0] : b[7:2];
    l3 = f[1] ? {1'b0, b[1:0], g[1:0], r[1:0]}
      : {1'b0, b[7:6], g[7:6], r[7:6]};
    if (!f[3]) l3 = 7'h00;
    exp_lanes = {l3, s[2] ^ f[7], s[0] ^ f[5], s[1] ^ f[6], b6[5:2],
      b6[1:0], g6[5:1], g6[0], r6};
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(FMT_OFFSET, d, r);
    chk(d, 32'h70, "format reset");
    chk(32'(r), 32'(RESP_OKAY), "read resp");
    chk(32'(fle), 32'h0, "lane off at reset");
    chk(32'(link_active), 32'h0, "link off at reset");
  endtask
  task automatic t_format(input logic [7:0] f);
    logic [31:0] d;
    logic [1:0] r;
    logic [23:0] c;
    logic [2:0] s;
    axi_wr(FMT_OFFSET, {24'h0, f}, r);
    axi_rd(FMT_OFFSET, d, r);
    chk(d, {24'h0, f & FMT_WMASK}, "format readback");
    for (int j = 0; j < 2; j++) begin
      c = j ? 24'h2894c6 : 24'hd76b39;
      s = j ? 3'b000 : 3'b111;
      if (!f[1]) c = c & 24'hfcfcfc;
      send_px(c, s);
      chk(32'(seen), 32'(exp_lanes(f, c, s)), "lanes");
      chk(32'(fle), 32'(f[3]), "fourth lane");
    end
  endtask
  task automatic t_idle();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(STATUS_OFFSET, d, r);
    chk(d, 32'((1 << STAT_LINK_BIT) | (1 << STAT_INFRAME_BIT)), "status run");
    axi_rd(FRAMES_OFFSET, d, r);
    chk(d, 32'h6, "frame count");
    send_px(24'h000000, 3'b000);
    chk(32'(link_active), 32'h1, "link on");
    repeat (60) @(posedge aclk);
    chk(32'(link_active), 32'h0, "link idle");
    axi_rd(STATUS_OFFSET, d, r);
    chk(d, 32'h0, "status idle");
  endtask
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h40, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
    axi_rd(8'h40, d, r);
    chk(d, 32'h0, "unmapped data");
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    wstrb_use = 4'he;
    axi_wr(FMT_OFFSET, 32'h0, r);
    wstrb_use = 4'hf;
    chk(32'(r), 32'(RESP_OKAY), "masked write");
    axi_rd(FMT_OFFSET, d, r);
    chk(d, 32'hf0, "format kept");
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, pix_clk} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    pix_in = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_format(8'h70);
    t_format(8'h78);
    t_format(8'h7a);
    t_format(8'h72);
    t_format(8'h10);
    t_format(8'hf0);
    t_idle();
    t_unmapped();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    stop_test();
  end
endmodule
